// ==== design/cs_pkg.sv ====
// constants for the chip-select decode block: register layouts, reset values, encodings
// assumes a 24-bit cpu address whose bits 23:20 copy bit 19
package cs_pkg;
  // ==========================================================
  // sizes
  localparam int NUM_GEN = 11;
  localparam int NUM_SEL = 12;
  localparam int BOOT_IDX = 11;
  // ==========================================================
  // base register layout
  localparam int BASE_ADDR_HI = 15;
  localparam int BASE_ADDR_LO = 3;
  localparam int BASE_BLK_HI = 2;
  localparam int BASE_BLK_LO = 0;
  localparam logic [15:0] GEN_BASE_RST = 16'h0000;
  localparam logic [15:0] BOOT_BASE_RST = 16'h0006;
  // ==========================================================
  // option register layout
  localparam int OPT_MODE = 15;
  localparam int OPT_BYTE_HI = 14;
  localparam int OPT_BYTE_LO = 13;
  localparam int OPT_RW_HI = 12;
  localparam int OPT_RW_LO = 11;
  localparam int OPT_STRB = 10;
  localparam int OPT_TACK_HI = 9;
  localparam int OPT_TACK_LO = 6;
  localparam int OPT_SPACE_HI = 5;
  localparam int OPT_SPACE_LO = 4;
  localparam int OPT_PRIO_HI = 3;
  localparam int OPT_PRIO_LO = 1;
  localparam int OPT_AUTOVEC = 0;
  localparam logic [15:0] GEN_OPT_RST = 16'h0000;
  localparam logic [15:0] BOOT_OPT_RST = 16'h7B60;
  // ==========================================================
  // encodings
  localparam logic [1:0] SPACE_CPU = 2'h0;
  localparam logic [1:0] SPACE_USER = 2'h1;
  localparam logic [1:0] SPACE_SUPV = 2'h2;
  localparam logic [1:0] SPACE_BOTH = 2'h3;
  localparam logic [1:0] BYTE_OFF = 2'h0;
  localparam logic [1:0] BYTE_LOWER = 2'h1;
  localparam logic [1:0] BYTE_UPPER = 2'h2;
  localparam logic [1:0] BYTE_BOTH = 2'h3;
  localparam logic [1:0] RW_READ = 2'h1;
  localparam logic [1:0] RW_WRITE = 2'h2;
  localparam logic [1:0] RW_BOTH = 2'h3;
  localparam logic [1:0] PA_PORT8 = 2'h2;
  localparam logic [1:0] PA_PORT16 = 2'h3;
  localparam logic [3:0] TACK_FAST = 4'hE;
  localparam logic [3:0] TACK_EXT = 4'hF;
  localparam logic [2:0] FCODE_CPU = 3'h7;
  localparam logic [2:0] PRIO_ANY = 3'h0;
  localparam logic [3:0] IACK_TYPE = 4'hF;
  // ==========================================================
  // configuration port selectors
  localparam logic [4:0] SEL_BASE0 = 5'h00;
  localparam logic [4:0] SEL_OPT0 = 5'h0C;
  localparam logic [4:0] SEL_PA_LOW = 5'h18;
  localparam logic [4:0] SEL_PA_HIGH = 5'h19;
  localparam int PA_LOW_W = 14;
  localparam int PA_HIGH_W = 10;
  // ==========================================================
  // slow bus clock phase: toggles once every ECLK_DIV cycles of ref_clk
  localparam int ECLK_DIV = 8;
  // data line whose strap gives the high pin-assign bit of each general select
  function automatic int strap_bit(input int k);
    int tbl[NUM_GEN];
    tbl = '{1, 1, 1, 2, 2, 2, 3, 4, 5, 6, 7};
    return tbl[k];
  endfunction : strap_bit
endpackage : cs_pkg

// ==== design/cs_match.sv ====
// one chip-select compare unit: all qualifiers of one select against the current cycle
// assumes inputs are stable in the cycle they are looked at; purely combinational
`timescale 1ns/1ps
`default_nettype none
module cs_match (
  input wire logic [15:0] base,
  input wire logic [15:0] option,
  input wire logic [1:0] pin_field,
  input wire logic [23:0] addr,
  input wire logic [1:0] space,
  input wire logic is_read,
  input wire logic is_word,
  input wire logic is_iack,
  output logic hit
);
  // ==========================================================
  // field decode
  logic [1:0] byte_f;
  logic [1:0] rw_f;
  logic [1:0] space_f;
  logic [2:0] prio_f;
  logic [4:0] low_bit;
  logic [12:0] cmp_mask;
  logic addr_ok, space_ok, rw_ok, byte_ok, prio_ok, pin_ok;

  assign byte_f = option[cs_pkg::OPT_BYTE_HI:cs_pkg::OPT_BYTE_LO];
  assign rw_f = option[cs_pkg::OPT_RW_HI:cs_pkg::OPT_RW_LO];
  assign space_f = option[cs_pkg::OPT_SPACE_HI:cs_pkg::OPT_SPACE_LO];
  assign prio_f = option[cs_pkg::OPT_PRIO_HI:cs_pkg::OPT_PRIO_LO];

  // lowest address bit compared for each block size code
  always_comb begin
    case (base[cs_pkg::BASE_BLK_HI:cs_pkg::BASE_BLK_LO])
      3'h0: low_bit = 5'd11;
      3'h1: low_bit = 5'd13;
      3'h2: low_bit = 5'd14;
      3'h3: low_bit = 5'd16;
      3'h4: low_bit = 5'd17;
      3'h5: low_bit = 5'd18;
      3'h6: low_bit = 5'd19;
      default: low_bit = 5'd20;
    endcase
  end

  // base bits 15:3 face address bits 23:11
  genvar i;
  generate
    for (i = 0; i < 13; i++) begin : g_mask
      assign cmp_mask[i] = (5'(i + 11) >= low_bit);
    end
  endgenerate
  assign addr_ok = ((base[cs_pkg::BASE_ADDR_HI:cs_pkg::BASE_ADDR_LO] ^ addr[23:11])
                    & cmp_mask) == 13'h0000;

  assign space_ok = (space_f == cs_pkg::SPACE_BOTH && space != cs_pkg::SPACE_CPU)
                    || (space_f == space);
  assign rw_ok = (rw_f == cs_pkg::RW_BOTH) || (rw_f == cs_pkg::RW_READ && is_read)
                 || (rw_f == cs_pkg::RW_WRITE && !is_read);
  assign pin_ok = (pin_field == cs_pkg::PA_PORT8) || (pin_field == cs_pkg::PA_PORT16);

  // a disabled byte field keeps the select quiet on any port
  always_comb begin
    if (byte_f == cs_pkg::BYTE_OFF) begin
      byte_ok = 1'b0;
    end else if (pin_field == cs_pkg::PA_PORT8 || byte_f == cs_pkg::BYTE_BOTH) begin
      byte_ok = 1'b1;
    end else if (byte_f == cs_pkg::BYTE_UPPER) begin
      byte_ok = !addr[0];
    end else begin
      byte_ok = addr[0] || is_word;
    end
  end

  // priority only looked at in cpu space; zero mask takes any level
  assign prio_ok = (space_f != cs_pkg::SPACE_CPU) || !is_iack
                   || (prio_f == cs_pkg::PRIO_ANY) || (prio_f == addr[3:1]);

  assign hit = addr_ok && space_ok && rw_ok && byte_ok && prio_ok && pin_ok;
endmodule : cs_match
`default_nettype wire

// ==== design/chip_select_iack_and_reset.sv ====
// chip-select decode with interrupt acknowledge support and strapped reset configuration
// assumes cpu cycle signals on ref_clk; data_in comes from pins and is synchronised here
`timescale 1ns/1ps
`default_nettype none
module chip_select_iack_and_reset (
  input wire logic ref_clk,
  input wire logic rst_n,
  // data lines read for reset straps
  input wire logic [7:0] data_in,
  // configuration write and read-back
  input wire logic cfg_wr,
  input wire logic [4:0] cfg_sel,
  input wire logic [15:0] cfg_wdata,
  output logic [15:0] cfg_rdata,
  // cpu cycle
  input wire logic cyc_active,
  input wire logic [23:0] cyc_addr,
  input wire logic [2:0] cyc_func_code,
  input wire logic cyc_read,
  input wire logic cyc_word,
  input wire logic address_strobe,
  input wire logic data_strobe,
  // interrupt acknowledge request
  input wire logic iack_req,
  input wire logic [2:0] iack_level,
  input wire logic iack_internal,
  // external bus
  output logic [23:0] ext_addr,
  output logic [2:0] function_code_lines,
  output logic [10:0] cs_n,
  output logic boot_select_n,
  output logic transfer_ack_n,
  output logic autovector_request_n,
  output logic boot_port_16
);
  // ==========================================================
  // registers
  logic [15:0] base_reg [cs_pkg::NUM_SEL];
  logic [15:0] opt_reg [cs_pkg::NUM_SEL];
  logic [cs_pkg::PA_LOW_W-1:0] pin_assign_reg_low;
  logic [cs_pkg::PA_HIGH_W-1:0] pin_assign_reg_high;
  logic [7:0] data_s1_reg, data_s2_reg;
  logic [23:0] strap_pa;
  logic [23:0] pa_all;

  // two flops before any logic reads the data pins
  always_ff @(posedge ref_clk) begin
    data_s1_reg <= data_in;
    data_s2_reg <= data_s1_reg;
  end

  // strap vector: field 0 is boot, fields 1..11 are general selects
  assign strap_pa[1:0] = {1'b1, data_s2_reg[0]};
  genvar k;
  generate
    for (k = 0; k < cs_pkg::NUM_GEN; k++) begin : g_strap
      assign strap_pa[2*k+3:2*k+2] = {data_s2_reg[cs_pkg::strap_bit(k)], 1'b1};
    end
  endgenerate
  assign pa_all = {pin_assign_reg_high, pin_assign_reg_low};

  // straps are caught on every edge while reset is held
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_assign_reg_low <= strap_pa[cs_pkg::PA_LOW_W-1:0];
      pin_assign_reg_high <= strap_pa[23:cs_pkg::PA_LOW_W];
    end else if (cfg_wr && cfg_sel == cs_pkg::SEL_PA_LOW) begin
      pin_assign_reg_low <= cfg_wdata[cs_pkg::PA_LOW_W-1:0];
    end else if (cfg_wr && cfg_sel == cs_pkg::SEL_PA_HIGH) begin
      pin_assign_reg_high <= cfg_wdata[cs_pkg::PA_HIGH_W-1:0];
    end
  end

  // base and option registers with their reset defaults
  generate
    for (k = 0; k < cs_pkg::NUM_SEL; k++) begin : g_regs
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          if (k == cs_pkg::BOOT_IDX) begin
            base_reg[k] <= cs_pkg::BOOT_BASE_RST;
            opt_reg[k] <= cs_pkg::BOOT_OPT_RST;
          end else begin
            base_reg[k] <= cs_pkg::GEN_BASE_RST;
            opt_reg[k] <= cs_pkg::GEN_OPT_RST;
          end
        end else if (cfg_wr && cfg_sel == 5'(cs_pkg::SEL_BASE0 + k)) begin
          base_reg[k] <= cfg_wdata;
        end else if (cfg_wr && cfg_sel == 5'(cs_pkg::SEL_OPT0 + k)) begin
          opt_reg[k] <= cfg_wdata;
        end
      end
    end
  endgenerate

  // read-back of any register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cfg_rdata <= 16'h0000;
    end else if (cfg_sel < cs_pkg::SEL_OPT0) begin
      cfg_rdata <= base_reg[cfg_sel[3:0]];
    end else if (cfg_sel < cs_pkg::SEL_PA_LOW) begin
      cfg_rdata <= opt_reg[4'(cfg_sel - cs_pkg::SEL_OPT0)];
    end else if (cfg_sel == cs_pkg::SEL_PA_LOW) begin
      cfg_rdata <= {2'h0, pin_assign_reg_low};
    end else if (cfg_sel == cs_pkg::SEL_PA_HIGH) begin
      cfg_rdata <= {6'h00, pin_assign_reg_high};
    end else begin
      cfg_rdata <= 16'h0000;
    end
  end

  // ==========================================================
  // cycle address and space
  logic [23:0] eff_addr;
  logic [2:0] eff_func_code;
  logic [1:0] eff_space;
  logic eff_iack;

  always_comb begin
    if (iack_req) begin
      eff_func_code = cs_pkg::FCODE_CPU;
      eff_addr = {4'hF, cs_pkg::IACK_TYPE, 12'hFFF, iack_level, 1'b1};
    end else begin
      eff_func_code = cyc_func_code;
      eff_addr = {{4{cyc_addr[19]}}, cyc_addr[19:0]};
    end
  end

  always_comb begin
    if (eff_func_code == cs_pkg::FCODE_CPU) begin
      eff_space = cs_pkg::SPACE_CPU;
    end else if (eff_func_code[2]) begin
      eff_space = cs_pkg::SPACE_SUPV;
    end else begin
      eff_space = cs_pkg::SPACE_USER;
    end
  end
  assign eff_iack = (eff_space == cs_pkg::SPACE_CPU)
                    && (eff_addr[19:16] == cs_pkg::IACK_TYPE);

  // ==========================================================
  // compare units, boot select last
  logic [cs_pkg::NUM_SEL-1:0] hit;
  logic [1:0] pin_field [cs_pkg::NUM_SEL];
  generate
    for (k = 0; k < cs_pkg::NUM_SEL; k++) begin : g_match
      if (k == cs_pkg::BOOT_IDX) begin : g_boot
        assign pin_field[k] = pa_all[1:0];
      end else begin : g_gen
        assign pin_field[k] = pa_all[2*k+3:2*k+2];
      end
      cs_match u_match (
        .base(base_reg[k]),
        .option(opt_reg[k]),
        .pin_field(pin_field[k]),
        .addr(eff_addr),
        .space(eff_space),
        .is_read(cyc_read),
        .is_word(cyc_word),
        .is_iack(eff_iack),
        .hit(hit[k])
      );
    end
  endgenerate

  // ==========================================================
  // slow bus clock enable for synchronous mode
  logic [$clog2(cs_pkg::ECLK_DIV)-1:0] eclk_cnt_reg;
  logic eclk_phase_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      eclk_cnt_reg <= '0;
      eclk_phase_reg <= 1'b0;
    end else begin
      eclk_cnt_reg <= eclk_cnt_reg + 1'b1;
      if (eclk_cnt_reg == '1) begin
        eclk_phase_reg <= !eclk_phase_reg;
      end
    end
  end

  // ==========================================================
  // strobe timing per select
  logic [cs_pkg::NUM_SEL-1:0] qual;
  logic cyc_ok;
  // internal requests are answered by their own module, never by a select
  assign cyc_ok = cyc_active && !(eff_iack && iack_internal);
  generate
    for (k = 0; k < cs_pkg::NUM_SEL; k++) begin : g_qual
      always_comb begin
        if (opt_reg[k][cs_pkg::OPT_MODE]) begin
          qual[k] = eclk_phase_reg;
        end else if (opt_reg[k][cs_pkg::OPT_STRB]) begin
          qual[k] = data_strobe;
        end else begin
          qual[k] = address_strobe;
        end
      end
    end
  endgenerate

  // ==========================================================
  // winning select for termination: lowest general index, boot last
  logic [3:0] win_idx;
  logic win_any;
  always_comb begin
    win_idx = 4'(cs_pkg::BOOT_IDX);
    win_any = cyc_ok && hit[cs_pkg::BOOT_IDX];
    for (int j = cs_pkg::NUM_GEN - 1; j >= 0; j--) begin
      if (cyc_ok && hit[j]) begin
        win_idx = 4'(j);
        win_any = 1'b1;
      end
    end
  end

  logic [3:0] win_tack_code;
  logic win_autovec;
  assign win_tack_code = opt_reg[win_idx][cs_pkg::OPT_TACK_HI:cs_pkg::OPT_TACK_LO];
  // autovector only counts in cpu space
  assign win_autovec = opt_reg[win_idx][cs_pkg::OPT_AUTOVEC]
                    && opt_reg[win_idx][cs_pkg::OPT_SPACE_HI:cs_pkg::OPT_SPACE_LO]
                       == cs_pkg::SPACE_CPU;

  // wait-state counter, runs from the start of each cycle
  logic [3:0] wait_cnt_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !cyc_active) begin
      wait_cnt_reg <= 4'h0;
    end else if (wait_cnt_reg != 4'hF) begin
      wait_cnt_reg <= wait_cnt_reg + 4'h1;
    end
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cs_n <= 11'h7FF;
      boot_select_n <= 1'b1;
    end else begin
      cs_n <= ~(hit[cs_pkg::NUM_GEN-1:0] & qual[cs_pkg::NUM_GEN-1:0]
               & {cs_pkg::NUM_GEN{cyc_ok}});
      boot_select_n <= !(cyc_ok && hit[cs_pkg::BOOT_IDX] && qual[cs_pkg::BOOT_IDX]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ext_addr <= 24'h000000;
      function_code_lines <= 3'h0;
    end else begin
      ext_addr <= eff_addr;
      function_code_lines <= eff_func_code;
    end
  end

  // autovector ends a vectorless acknowledge; otherwise transfer ack after waits
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      autovector_request_n <= 1'b1;
      transfer_ack_n <= 1'b1;
    end else if (win_any && eff_iack && win_autovec) begin
      autovector_request_n <= 1'b0;
      transfer_ack_n <= 1'b1;
    end else if (win_any && win_tack_code == cs_pkg::TACK_FAST) begin
      autovector_request_n <= 1'b1;
      transfer_ack_n <= 1'b0;
    end else begin
      autovector_request_n <= 1'b1;
      transfer_ack_n <= !(win_any && win_tack_code != cs_pkg::TACK_EXT
                          && wait_cnt_reg >= win_tack_code);
    end
  end

  // boot port is 16 bits when the whole boot pin field equals PA_PORT16
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      boot_port_16 <= 1'b0;
    end else begin
      boot_port_16 <= pa_all[1:0] == cs_pkg::PA_PORT16;
    end
  end
endmodule : chip_select_iack_and_reset
`default_nettype wire

// ==== tb/strap_driver.sv ====
// far-side model of the data lines: an active driver holding reset straps
// assumes weak pull-ups on every data line once the driver lets go
`timescale 1ns/1ps
`default_nettype none
module strap_driver (
  input wire logic rst_n,
  input wire logic drive_en,
  input wire logic [7:0] strap_val,
  output logic [7:0] data_in
);
  // a released line floats to the pull-up level, which picks chip-select function
  assign data_in = (!rst_n && drive_en) ? strap_val : 8'hFF;
endmodule : strap_driver
`default_nettype wire

// ==== tb/chip_select_iack_and_reset_chk.sv ====
// port-level checker for the chip-select decode block
// assumes one clock domain and synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module chip_select_iack_and_reset_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] data_in,
  input wire logic cfg_wr,
  input wire logic [4:0] cfg_sel,
  input wire logic cyc_active,
  input wire logic [23:0] cyc_addr,
  input wire logic iack_req,
  input wire logic [2:0] iack_level,
  input wire logic iack_internal,
  input wire logic [23:0] ext_addr,
  input wire logic [2:0] function_code_lines,
  input wire logic [10:0] cs_n,
  input wire logic boot_select_n,
  input wire logic transfer_ack_n,
  input wire logic autovector_request_n,
  input wire logic boot_port_16
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ========================================
  // strap seen during reset, and whether software overwrote it
  logic strap0_reg;
  logic pa_wr_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) strap0_reg <= data_in[0];
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) pa_wr_reg <= 1'b0;
    else if (cfg_wr && cfg_sel == 5'h18) pa_wr_reg <= 1'b1;
  end
  // ========================================
  // assertions
  chk_iack_code: assert property (
    cyc_active && iack_req |=> function_code_lines == 3'h7)
    else $error("function code not cpu space in acknowledge");
  chk_iack_addr: assert property (
    cyc_active && iack_req |=> ext_addr == (24'hFFFFF1 | {20'h0, $past(iack_level), 1'b0}))
    else $error("acknowledge address wrong");
  chk_addr_copy: assert property (
    cyc_active && !iack_req |=> ext_addr == {{4{$past(cyc_addr[19])}}, $past(cyc_addr[19:0])})
    else $error("upper address does not copy bit 19");
  chk_internal_quiet: assert property (
    iack_req && iack_internal |=> &cs_n && boot_select_n && transfer_ack_n
      && autovector_request_n)
    else $error("answer to internal acknowledge");
  chk_sel_idle: assert property (
    !cyc_active |=> (&cs_n) && boot_select_n)
    else $error("select outside a bus cycle");
  chk_ack_idle: assert property (
    !cyc_active ##1 !cyc_active |-> transfer_ack_n && autovector_request_n)
    else $error("termination outside a bus cycle");
  chk_autovec_iack_only: assert property (
    !iack_req |=> autovector_request_n)
    else $error("autovector outside acknowledge");
  chk_boot_width: assert property (
    $past(rst_n, 2) && !pa_wr_reg |-> boot_port_16 == strap0_reg)
    else $error("boot port width differs from strap");
  cover property (!boot_select_n);
  cover property (!autovector_request_n);
  cover property (!transfer_ack_n && !cs_n[0]);
endmodule : chip_select_iack_and_reset_chk
bind chip_select_iack_and_reset chip_select_iack_and_reset_chk i_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .data_in(data_in), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel),
  .cyc_active(cyc_active), .cyc_addr(cyc_addr), .iack_req(iack_req),
  .iack_level(iack_level), .iack_internal(iack_internal), .ext_addr(ext_addr),
  .function_code_lines(function_code_lines), .cs_n(cs_n), .boot_select_n(boot_select_n),
  .transfer_ack_n(transfer_ack_n), .autovector_request_n(autovector_request_n),
  .boot_port_16(boot_port_16));
`default_nettype wire

// ==== tb/chip_select_iack_and_reset_bench.sv ====
// self-checking bench for the chip-select decode block
// assumes the strap driver model on the data lines and the bound checker
`timescale 1ns/1ps
`default_nettype none
module chip_select_iack_and_reset_bench;
  logic ref_clk, rst_n, cfg_wr, cyc_active, cyc_read, address_strobe, data_strobe;
  logic iack_req, iack_internal, drive_en, boot_select_n, transfer_ack_n;
  logic autovector_request_n, boot_port_16, cyc_word;
  logic [4:0] cfg_sel;
  logic [15:0] cfg_wdata, cfg_rdata;
  logic [23:0] cyc_addr, ext_addr;
  logic [2:0] cyc_func_code, iack_level, function_code_lines;
  logic [7:0] data_in, strap_val;
  logic [10:0] cs_n;
  int num_errors = 0;
  int samples_checked = 0;
  strap_driver i_strap_driver (.rst_n(rst_n), .drive_en(drive_en), .strap_val(strap_val),
    .data_in(data_in));
  chip_select_iack_and_reset i_chip_select_iack_and_reset (.ref_clk(ref_clk), .rst_n(rst_n),
    .data_in(data_in), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cyc_active(cyc_active), .cyc_addr(cyc_addr),
    .cyc_func_code(cyc_func_code), .cyc_read(cyc_read), .cyc_word(cyc_word),
    .address_strobe(address_strobe),
    .data_strobe(data_strobe), .iack_req(iack_req), .iack_level(iack_level),
    .iack_internal(iack_internal), .ext_addr(ext_addr),
    .function_code_lines(function_code_lines), .cs_n(cs_n), .boot_select_n(boot_select_n),
    .transfer_ack_n(transfer_ack_n), .autovector_request_n(autovector_request_n),
    .boot_port_16(boot_port_16));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // ========================================
  // helpers
  task stop_test();
    if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  task check(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task do_reset(input logic en, input logic [7:0] v);
    drive_en <= en;
    strap_val <= v;
    rst_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask : do_reset
  task cfg_w(input logic [4:0] s, input logic [15:0] d);
    cfg_wr <= 1'b1;
    cfg_sel <= s;
    cfg_wdata <= d;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : cfg_w
  task cfg_r(input logic [4:0] s, input logic [15:0] exp);
    cfg_sel <= s;
    repeat (2) @(posedge ref_clk);
    #1;
    check(24'(cfg_rdata), 24'(exp));
    @(posedge ref_clk);
  endtask : cfg_r
  // data line feeding the high pin-assign bit of general selects 0 to 10
  function automatic logic [23:0] exp_pa(input logic [7:0] v);
    int ln[11];
    logic [23:0] p;
    ln = '{1, 1, 1, 2, 2, 2, 3, 4, 5, 6, 7};
    p = 24'h000000;
    p[1:0] = {1'b1, v[0]};
    for (int k = 0; k < 11; k++) p[2 + 2 * k +: 2] = {v[ln[k]], 1'b1};
    return p;
  endfunction : exp_pa
  task check_straps(input logic [7:0] v);
    logic [23:0] p;
    p = exp_pa(v);
    cfg_r(5'h18, {2'h0, p[13:0]});
    cfg_r(5'h19, {6'h0, p[23:14]});
    check(24'(boot_port_16), 24'(v[0]));
  endtask : check_straps
  // one bus cycle; eack is the expected cycle count to the ack, 0 for none
  task bus(input logic [23:0] a, input logic [2:0] f, input logic rd, input logic ik,
    input logic [2:0] lv, input logic in, input logic [10:0] ecs, input logic eb,
    input logic ev, input int eack);
    int n;
    cyc_addr <= a;
    cyc_func_code <= f;
    cyc_read <= rd;
    iack_req <= ik;
    iack_level <= lv;
    iack_internal <= in;
    cyc_active <= 1'b1;
    address_strobe <= 1'b1;
    data_strobe <= 1'b1;
    @(posedge ref_clk);
    #1;
    check(24'(cs_n), 24'(ecs));
    check(24'(boot_select_n), 24'(eb));
    check(24'(autovector_request_n), 24'(ev));
    if (ik && !in) check(ext_addr, 24'hFFFFF1 | {20'h0, lv, 1'b0});
    n = 1;
    while (transfer_ack_n !== 1'b0 && n < 16) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(24'(n), 24'(eack == 0 ? 16 : eack));
    if (eack != 0 && n == 16) stop_test();
    @(posedge ref_clk);
    cyc_active <= 1'b0;
    address_strobe <= 1'b0;
    data_strobe <= 1'b0;
    iack_req <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : bus
  // ========================================
  // test sequence
  initial begin
    {rst_n, cfg_wr, cyc_active, cyc_read, address_strobe, data_strobe} = 6'h00;
    {iack_req, iack_internal, drive_en, cyc_word} = 4'h1;
    {cfg_sel, cfg_wdata, cyc_addr, cyc_func_code, iack_level, strap_val} = 0;
    do_reset(1'b0, 8'h00);
    for (int k = 0; k < 11; k++) begin
      cfg_r(5'(k), 16'h0000);
      cfg_r(5'(k + 12), 16'h0000);
    end
    cfg_r(5'h0B, 16'h0006);
    cfg_r(5'h17, 16'h7B60);
    check_straps(8'hFF);
    bus(24'h000000, 3'h6, 1'b1, 1'b0, 3'h0, 1'b0, 11'h7FF, 1'b0, 1'b1, 14);
    bus(24'h07FFFE, 3'h6, 1'b0, 1'b0, 3'h0, 1'b0, 11'h7FF, 1'b0, 1'b1, 14);
    bus(24'h080000, 3'h6, 1'b1, 1'b0, 3'h0, 1'b0, 11'h7FF, 1'b1, 1'b1, 0);
    bus(24'h000000, 3'h1, 1'b1, 1'b0, 3'h0, 1'b0, 11'h7FF, 1'b1, 1'b1, 0);
    cfg_w(5'h01, 16'h0100);
    cfg_w(5'h0D, 16'h7820);
    bus(24'h010400, 3'h6, 1'b1, 1'b0, 3'h0, 1'b0, 11'h7FD, 1'b0, 1'b1, 1);
    bus(24'h010800, 3'h6, 1'b1, 1'b0, 3'h0, 1'b0, 11'h7FF, 1'b0, 1'b1, 14);
    cfg_w(5'h0D, 16'h6820);
    bus(24'h010400, 3'h6, 1'b0, 1'b0, 3'h0, 1'b0, 11'h7FF, 1'b0, 1'b1, 14);
    cfg_w(5'h0D, 16'h7827);
    bus(24'h010400, 3'h6, 1'b1, 1'b0, 3'h0, 1'b0, 11'h7FD, 1'b0, 1'b1, 1);
    cfg_w(5'h0D, 16'h5820);
    cyc_word <= 1'b0;
    bus(24'h010401, 3'h6, 1'b1, 1'b0, 3'h0, 1'b0, 11'h7FF, 1'b0, 1'b1, 14);
    bus(24'h010400, 3'h6, 1'b1, 1'b0, 3'h0, 1'b0, 11'h7FD, 1'b0, 1'b1, 1);
    cyc_word <= 1'b1;
    cfg_w(5'h00, 16'hFFFB);
    cfg_w(5'h0C, 16'h2807);
    bus(24'h000000, 3'h0, 1'b1, 1'b1, 3'h3, 1'b0, 11'h7FE, 1'b1, 1'b0, 0);
    bus(24'h000000, 3'h0, 1'b1, 1'b1, 3'h5, 1'b0, 11'h7FF, 1'b1, 1'b1, 0);
    bus(24'h000000, 3'h0, 1'b1, 1'b1, 3'h3, 1'b1, 11'h7FF, 1'b1, 1'b1, 0);
    cfg_w(5'h0C, 16'h2801);
    bus(24'h000000, 3'h0, 1'b1, 1'b1, 3'h6, 1'b0, 11'h7FE, 1'b1, 1'b0, 0);
    cfg_w(5'h0C, 16'h2800);
    bus(24'h000000, 3'h0, 1'b1, 1'b1, 3'h6, 1'b0, 11'h7FE, 1'b1, 1'b1, 1);
    do_reset(1'b1, 8'h5A);
    check_straps(8'h5A);
    cfg_r(5'h01, 16'h0000);
    cfg_r(5'h0C, 16'h0000);
    bus(24'h000000, 3'h6, 1'b1, 1'b0, 3'h0, 1'b0, 11'h7FF, 1'b0, 1'b1, 14);
    stop_test();
  end
endmodule : chip_select_iack_and_reset_bench
`default_nettype wire
